// >>> src/dbt_defs.vh
// Register indices, control field positions and reset values for the dual byte timer.
`ifndef DBT_DEFS_VH
`define DBT_DEFS_VH

// Register indices; the Avalon byte address is four times the index.
`define DBT_IDX_CONTROL 16'hfe10
`define DBT_IDX_PRESCALE 16'hfe11
`define DBT_IDX_LOW_COUNT 16'hfe12
`define DBT_IDX_HIGH_COUNT 16'hfe13
`define DBT_IDX_LOW_DATA 16'hfe14
`define DBT_IDX_HIGH_DATA 16'hfe15
`define DBT_IDX_LOW_CAPTURE 16'hfe16
`define DBT_IDX_HIGH_CAPTURE 16'hfe17

// Byte address width that covers the highest index times four.
`define DBT_ADDR_W 18

// Control register field positions.
`define DBT_BIT_HIGH_RUN 7
`define DBT_BIT_LOW_RUN 6
`define DBT_BIT_LONG_MODE 5
`define DBT_BIT_LOW_EXT 4
`define DBT_BIT_HIGH_FLAG 3
`define DBT_BIT_HIGH_IE 2
`define DBT_BIT_LOW_FLAG 1
`define DBT_BIT_LOW_IE 0

// Reset values.
`define DBT_RST_CONTROL 8'h00
`define DBT_RST_PRESCALE 8'h00
`define DBT_RST_COUNT 8'h00
`define DBT_RST_DATA 8'h00
`define DBT_RST_CAPTURE 8'h00

// Interrupt vector addresses reported beside each request.
`define DBT_VEC_LOW 16'h0013
`define DBT_VEC_HIGH 16'h0023

`endif

// >>> src/dbt_prescaler.v
// Programmable prescaler that divides the cycle clock by its match value plus one.
`timescale 1ns/10ps
`include "dbt_defs.vh"

module dbt_prescaler #(
    parameter WIDTH = 8
) (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_run,
    input wire i_restart,
    input wire [WIDTH-1:0] i_match_value,
    output wire o_tick
);

    reg [WIDTH-1:0] count_q;

    // Match pulse is raised while the count equals the match value and counting is allowed.
    assign o_tick = i_run && (count_q == i_match_value); // RL1

    // Counter restarts on its own match and on every write of the match value.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            count_q <= {WIDTH{1'b0}};
        end else if (i_ce) begin
            if (i_restart) begin
                count_q <= {WIDTH{1'b0}}; // RL2
            end else if (o_tick) begin
                count_q <= {WIDTH{1'b0}}; // RL2
            end else if (i_run) begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1}; // RL3
            end
        end
    end

endmodule

// >>> src/dbt_timer.v
// Dual byte timer/counter with prescaler, match buffers and capture registers on Avalon-MM.
//
// Behaviour
// RL1: Prescaler counts cycle clocks and pulses when equal to its match register.
// RL2: Prescaler restarts from zero on its match and on a match register write.
// RL3: Prescaler runs in every mode except HOLD.
// RL4: Low counter runs while control bit 6 is one, stops while zero.
// RL5: High counter runs while control bit 7 is one, stops while zero.
// RL6: Control bit 4 picks low count source: prescaler pulse or input A/B strobe.
// RL7: Control bit 5 picks high count source: prescaler pulse or low-byte carry.
// RL8: Each counter clears when stopped and when it matches.
// RL9: Counter matches when equal to its buffer; 16-bit modes compare all bits.
// RL10: Stopped buffer follows its data register; running buffer loads only on match.
// RL11: Low capture takes strobes A or C, or B or C in long mode.
// RL12: High capture latches the high count on every B or C strobe.
// RL13: In 16-bit modes one B or C strobe loads both captures together.
// RL14: Long-mode and external bits together select modes zero to three.
// RL15: Mode three advances the 16-bit count once per A or B strobe.
// RL16: Each half requests an interrupt once per interval at its match when enabled.
// RL17: High match flag sets on a running high match; only software clears it.
// RL18: High flag and high enable together request the vector 0023H interrupt.
// RL19: Low flag and low enable together request the vector 0013H interrupt.
// RL20: In 16-bit mode both flags set together; software writes equal run bits.
// RL21: Counter registers read live counts; writes to them are ignored.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`include "dbt_defs.vh"

module dbt_timer #(
    parameter DATA_W = 8,
    parameter CLK_HZ = 25000000
) (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_hold_mode,
    input wire i_ext_input_a,
    input wire i_ext_input_b,
    input wire i_ext_input_c,
    input wire [`DBT_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output wire [31:0] o_avs_readdata,
    output wire o_avs_waitrequest,
    output wire o_low_irq,
    output wire o_high_irq,
    output wire [15:0] o_low_vector,
    output wire [15:0] o_high_vector,
    output wire [1:0] o_mode
);

    // Decodes a byte address into {hit, register number 0..7}.
    // The register index is the byte address divided by four.
    // Only word-aligned addresses inside the eight-register window hit;
    // every other address reads as zero and takes no write.
    function [3:0] dbt_reg_sel;
        input [`DBT_ADDR_W-1:0] addr;
        reg [15:0] idx;
        begin
            idx = addr[`DBT_ADDR_W-1:2];
            if ((addr[1:0] == 2'h0) && (idx >= `DBT_IDX_CONTROL) && (idx <= `DBT_IDX_HIGH_CAPTURE)) begin
                dbt_reg_sel = {1'b1, idx[2:0]};
            end else begin
                dbt_reg_sel = 4'h0;
            end
        end
    endfunction

    // Next value of a byte counter: clear, hold or advance.
    // Stopping forces zero, so a restart always begins a full interval.
    // Clear wins over advance because a match ends the interval.
    function [DATA_W-1:0] dbt_count_next;
        input run;
        input clear;
        input advance;
        input [DATA_W-1:0] value;
        begin
            if (!run || clear) begin
                dbt_count_next = {DATA_W{1'b0}};
            end else if (advance) begin
                dbt_count_next = value + {{(DATA_W-1){1'b0}}, 1'b1};
            end else begin
                dbt_count_next = value;
            end
        end
    endfunction

    // Next value of a match buffer: follow while stopped, reload on match while running.
    // Software may rewrite the data register at any time; a running
    // counter only sees the new value from the next interval on.
    // A stopped counter follows it at once.
    function [DATA_W-1:0] dbt_buffer_next;
        input run;
        input match;
        input [DATA_W-1:0] data;
        input [DATA_W-1:0] value;
        begin
            if (!run || match) begin
                dbt_buffer_next = data;
            end else begin
                dbt_buffer_next = value;
            end
        end
    endfunction

    // Register file and counter state.
    // The match buffers are hidden copies that software never reads.
    // The capture registers reset to zero.
    reg [7:0] control_q;
    reg [DATA_W-1:0] prescaler_match_q;
    reg [DATA_W-1:0] low_count_q;
    reg [DATA_W-1:0] high_count_q;
    reg [DATA_W-1:0] low_match_data_q;
    reg [DATA_W-1:0] high_match_data_q;
    reg [DATA_W-1:0] low_buffer_q;
    reg [DATA_W-1:0] high_buffer_q;
    reg [DATA_W-1:0] low_capture_q;
    reg [DATA_W-1:0] high_capture_q;
    reg [31:0] readdata_q;
    reg ack_q;

    // Decoded bus strobes, control fields and count pulses.
    wire [3:0] sel;
    wire req;
    wire wr_now;
    wire wr_lane;
    wire [7:0] wbyte;
    wire high_run;
    wire low_run;
    wire long_mode;
    wire low_external_clock;
    wire pre_tick;
    wire ext_ab;
    wire ext_bc;
    wire ext_ac;
    wire low_clk;
    wire high_clk;
    wire long_match;
    wire low_match;
    wire high_match;
    wire low_cap_strobe;
    wire high_cap_strobe;
    wire wr_control;
    wire wr_prescale;
    wire wr_low_data;
    wire wr_high_data;
    wire [7:0] flag_set;

    // Bus request decode; a write lands on the edge where waitrequest is low.
    // Only the low byte lane carries data, so a write without byte enable 0
    // completes on the bus but changes nothing.
    assign sel = dbt_reg_sel(i_avs_address);
    assign req = i_avs_read || i_avs_write;
    assign wr_now = i_avs_write && ack_q;
    assign wr_lane = wr_now && sel[3] && i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];
    assign wr_control = wr_lane && (sel[2:0] == 3'h0);
    assign wr_prescale = wr_lane && (sel[2:0] == 3'h1);
    assign wr_low_data = wr_lane && (sel[2:0] == 3'h4);
    assign wr_high_data = wr_lane && (sel[2:0] == 3'h5);

    // Every request waits exactly one cycle, then completes.
    // While the clock enable is low nothing can land, so the answer is
    // withheld; otherwise a master would see a write finish that the
    // frozen register file never took.
    assign o_avs_waitrequest = req && !(ack_q && i_ce);
    assign o_avs_readdata = readdata_q;

    // Control fields.
    // The mode number is formed from the long-mode and external-clock bits.
    // In long mode software keeps both run bits equal; the low one gates the match.
    assign high_run = control_q[`DBT_BIT_HIGH_RUN];
    assign low_run = control_q[`DBT_BIT_LOW_RUN];
    assign long_mode = control_q[`DBT_BIT_LONG_MODE];
    assign low_external_clock = control_q[`DBT_BIT_LOW_EXT];
    assign o_mode = {long_mode, low_external_clock}; // RL14

    // Prescaler runs in all modes except HOLD.
    // It is shared by both halves, so the two prescaled timers of mode 0
    // always step on the same cycle.
    dbt_prescaler #(
        .WIDTH(DATA_W)
    ) u_prescaler (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_run(!i_hold_mode), // RL3
        .i_restart(wr_prescale), // RL2
        .i_match_value(prescaler_match_q),
        .o_tick(pre_tick)
    );

    // Strobe groupings of the three detection inputs.
    // Each strobe is a one-cycle pulse from edge logic on this clock, so it
    // is used directly without synchronising flip-flops.
    // A level held high would count and capture on every cycle.
    assign ext_ab = i_ext_input_a || i_ext_input_b;
    assign ext_bc = i_ext_input_b || i_ext_input_c;
    assign ext_ac = i_ext_input_a || i_ext_input_c;

    // Count sources; in long mode the high byte advances on the low byte's carry.
    // The low byte never matches on its own in long mode, so its carry from
    // all ones to zero is what steps the high byte. This keeps both halves
    // one 16-bit counter whose period is the combined match value plus one.
    assign low_clk = low_external_clock ? ext_ab : pre_tick; // RL6 RL15
    assign high_clk = long_mode ? (low_clk && (low_count_q == {DATA_W{1'b1}})) : pre_tick; // RL7

    // Match detection, 8-bit per half or the full 16 bits in long mode.
    // A match needs a count pulse in the same cycle, so a counter parked on
    // its match value waits for its next pulse instead of firing every cycle.
    // The long-mode match is gated by the low run bit and drives both halves.
    assign long_match = low_run && low_clk &&
        ({high_count_q, low_count_q} == {high_buffer_q, low_buffer_q}); // RL9 RL15
    assign low_match = long_mode ? long_match : (low_run && low_clk && (low_count_q == low_buffer_q)); // RL9
    assign high_match = long_mode ? long_match : (high_run && high_clk && (high_count_q == high_buffer_q)); // RL9 RL20

    // Capture strobes; the same B or C strobe feeds both halves in long mode.
    // One strobe then snaps both bytes on one edge, so software never sees
    // a low byte that has wrapped past the high byte it read.
    assign low_cap_strobe = long_mode ? ext_bc : ext_ac; // RL11 RL13
    assign high_cap_strobe = ext_bc; // RL12

    // Hardware flag sets; they win over a software clear in the same cycle.
    // Losing a match to a clear that lands on the same edge would drop an
    // interrupt, which is worse than one that software must clear again.
    assign flag_set = {4'h0, high_match, 1'b0, low_match, 1'b0}; // RL16 RL17 RL20

    // Interrupt requests and their vectors.
    // Requests are levels that stay high until software clears the flag.
    // The vectors are fixed and only tell the controller where to go.
    assign o_low_irq = control_q[`DBT_BIT_LOW_FLAG] && control_q[`DBT_BIT_LOW_IE]; // RL19
    assign o_high_irq = control_q[`DBT_BIT_HIGH_FLAG] && control_q[`DBT_BIT_HIGH_IE]; // RL18
    assign o_low_vector = `DBT_VEC_LOW;
    assign o_high_vector = `DBT_VEC_HIGH;

    // Bus handshake: one wait cycle, read data captured in the first cycle of a read.
    // The read value is taken on the edge that ends the wait cycle and then
    // stands until the next read, so the master finds it settled when
    // waitrequest drops. Unmapped reads return zero.
    // Writes land on the edge where waitrequest is sampled low.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            ack_q <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            ack_q <= req && !ack_q;
            if (i_avs_read && !ack_q) begin
                readdata_q <= 32'h0000_0000;
                if (sel[3]) begin
                    case (sel[2:0])
                        3'h0: begin
                            readdata_q[7:0] <= control_q;
                        end
                        3'h1: begin
                            readdata_q[7:0] <= prescaler_match_q;
                        end
                        3'h2: begin
                            readdata_q[7:0] <= low_count_q; // RL21
                        end
                        3'h3: begin
                            readdata_q[7:0] <= high_count_q; // RL21
                        end
                        3'h4: begin
                            readdata_q[7:0] <= low_match_data_q;
                        end
                        3'h5: begin
                            readdata_q[7:0] <= high_match_data_q;
                        end
                        3'h6: begin
                            readdata_q[7:0] <= low_capture_q;
                        end
                        default: begin
                            readdata_q[7:0] <= high_capture_q;
                        end
                    endcase
                end
            end
        end
    end

    // Software-written registers; the count registers take no write.
    // A write of the prescaler match also restarts the prescaler, so the
    // new tick period starts cleanly from zero.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            control_q <= `DBT_RST_CONTROL;
            prescaler_match_q <= `DBT_RST_PRESCALE;
            low_match_data_q <= `DBT_RST_DATA;
            high_match_data_q <= `DBT_RST_DATA;
        end else if (i_ce) begin
            if (wr_control) begin
                control_q <= wbyte | flag_set; // RL17
            end else begin
                control_q <= control_q | flag_set; // RL17 RL20
            end
            if (wr_prescale) begin
                prescaler_match_q <= wbyte;
            end
            if (wr_low_data) begin
                low_match_data_q <= wbyte;
            end
            if (wr_high_data) begin
                high_match_data_q <= wbyte;
            end
        end
    end

    // Byte counters and their match buffers.
    // Both halves update on the same edge from the same match signals, so
    // in long mode the counts and buffers of the two bytes never disagree.
    // A stopped half stays at zero whatever its count source does.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            low_count_q <= `DBT_RST_COUNT;
            high_count_q <= `DBT_RST_COUNT;
            low_buffer_q <= `DBT_RST_DATA;
            high_buffer_q <= `DBT_RST_DATA;
        end else if (i_ce) begin
            low_count_q <= dbt_count_next(low_run, low_match, low_clk, low_count_q); // RL4 RL8
            high_count_q <= dbt_count_next(high_run, high_match, high_clk, high_count_q); // RL5 RL8
            low_buffer_q <= dbt_buffer_next(low_run, low_match, low_match_data_q, low_buffer_q); // RL10
            high_buffer_q <= dbt_buffer_next(high_run, high_match, high_match_data_q, high_buffer_q); // RL10
        end
    end

    // Capture registers snap the live counts on their strobes.
    // They take the value held before the edge, which is the count that
    // software would have read in the cycle of the strobe.
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            low_capture_q <= `DBT_RST_CAPTURE;
            high_capture_q <= `DBT_RST_CAPTURE;
        end else if (i_ce) begin
            if (low_cap_strobe) begin
                low_capture_q <= low_count_q; // RL11 RL13
            end
            if (high_cap_strobe) begin
                high_capture_q <= high_count_q; // RL12 RL13
            end
        end
    end

endmodule

// >>> tb/dbt_timer_props.sv
// Port-level concurrent checks for the dual byte timer.
`timescale 1ns/10ps
`include "dbt_defs.vh"
module dbt_timer_chk (
    input wire i_core_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [17:0] i_avs_address,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest,
    input wire o_low_irq,
    input wire o_high_irq,
    input wire [15:0] o_low_vector,
    input wire [15:0] o_high_vector,
    input wire [1:0] o_mode
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    // Request decode used by the bus checks.
    wire req = i_avs_read | i_avs_write;
    wire [15:0] idx = i_avs_address[17:2];
    wire mapped = (i_avs_address[1:0] == 2'h0) && (idx >= 16'hfe10) && (idx <= 16'hfe17);
    wire ctl = (i_avs_address == {16'hfe10, 2'h0});
    wire done = i_avs_write && !o_avs_waitrequest && i_ce;
    one_wait_a: assert property (req && o_avs_waitrequest && i_ce ##1 i_ce |-> !o_avs_waitrequest)
        else $error("bus answer late");
    idle_wait_a: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest while idle");
    first_wait_a: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("no wait cycle");
    rd_upper_a: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    rd_unmapped_a: assert property (i_avs_read && o_avs_waitrequest && i_ce && !mapped |=> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    mode_write_a: assert property (done && ctl && i_avs_byteenable[0] |=> o_mode == $past(i_avs_writedata[5:4]))
        else $error("mode not from control write");
    mode_read_a: assert property (i_avs_read && o_avs_waitrequest && ctl && i_ce |=> o_avs_readdata[5:4] == o_mode)
        else $error("mode readback differs");
    mode_hold_a: assert property (!$past(i_avs_write) |-> $stable(o_mode))
        else $error("mode changed without write");
    flag_keep_a: assert property ($fell(o_low_irq) || $fell(o_high_irq) |-> $past(done))
        else $error("request dropped by hardware");
    vector_a: assert property (o_low_vector == `DBT_VEC_LOW && o_high_vector == `DBT_VEC_HIGH)
        else $error("vector wrong");
    cover property ($rose(o_low_irq));
    cover property ($rose(o_high_irq) && o_mode == 2'h2);
    cover property (o_mode == 2'h3 && o_low_irq);
endmodule
bind dbt_timer dbt_timer_chk u_chk (.*);

// >>> tb/tb_dbt_timer.sv
// Self-checking testbench for the dual byte timer.
`timescale 1ns/10ps
`include "dbt_defs.vh"
module tb_dbt_timer;
    localparam [15:0] B = `DBT_IDX_CONTROL;
    reg clk, srst, ce, hold, ea, eb, ec, rd, wr;
    reg [17:0] addr;
    reg [31:0] wdata;
    reg [3:0] be;
    wire [31:0] rdata;
    wire wt, lirq, hirq;
    wire [15:0] lvec, hvec;
    wire [1:0] mode;
    integer err_total, checks, cyc, d;
    reg [31:0] q1, q2;
    dbt_timer u_dut (.i_core_clk(clk), .i_srst(srst), .i_ce(ce), .i_hold_mode(hold), .i_ext_input_a(ea),
        .i_ext_input_b(eb), .i_ext_input_c(ec), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
        .o_low_irq(lirq), .o_high_irq(hirq), .o_low_vector(lvec), .o_high_vector(hvec), .o_mode(mode));
    // Clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Cycle stamp used to measure periods.
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
    end
    // Compares one value and counts the outcome.
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH at %0t seen %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One bus transfer held until waitrequest is sampled low.
    task xfer(input w, input [15:0] idx, input [7:0] dat, output [31:0] q);
        integer n;
        begin
            @(posedge clk);
            addr <= {idx, 2'h0};
            wdata <= {24'h0, dat};
            wr <= w;
            rd <= !w;
            n = 0;
            @(posedge clk);
            while (wt !== 1'b0 && n < 50) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 50) begin
                err_total = err_total + 1;
            end
            q = rdata;
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task bw(input [15:0] idx, input [7:0] dat);
        begin
            xfer(1'b1, idx, dat, q1);
        end
    endtask
    task rc(input [15:0] idx, input [7:0] exp);
        begin
            xfer(1'b0, idx, 8'h00, q1);
            chk(q1, {24'h0, exp});
        end
    endtask
    // One-cycle detection strobe on input a, b or c.
    task pulse(input integer k);
        begin
            @(posedge clk);
            ea <= (k == 0);
            eb <= (k == 1);
            ec <= (k == 2);
            @(posedge clk);
            ea <= 1'b0;
            eb <= 1'b0;
            ec <= 1'b0;
        end
    endtask
    task waitirq(input h);
        integer n;
        begin
            n = 0;
            @(negedge clk);
            while ((h ? hirq : lirq) !== 1'b1 && n < 3000) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n >= 3000) begin
                err_total = err_total + 1;
            end
        end
    endtask
    // Cycles between two request rises, flags cleared by control writes.
    task per(input h, input [7:0] c, output integer p);
        integer t0;
        begin
            bw(B, c);
            waitirq(h);
            t0 = cyc;
            bw(B, c);
            waitirq(h);
            p = cyc - t0;
        end
    endtask
    task t_regs;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) rc(B + i[15:0], 8'h00);
            bw(B + 16'h1, 8'ha5);
            rc(B + 16'h1, 8'ha5);
            bw(B + 16'h4, 8'h5a);
            rc(B + 16'h4, 8'h5a);
            bw(B + 16'h5, 8'h3c);
            rc(B + 16'h5, 8'h3c);
            bw(B + 16'h8, 8'h33);
            rc(B + 16'h8, 8'h00);
            chk({16'h0, lvec}, {16'h0, `DBT_VEC_LOW});
            chk({16'h0, hvec}, {16'h0, `DBT_VEC_HIGH});
            $display("register test done");
        end
    endtask
    task t_mode0;
        begin
            bw(B + 16'h1, 8'h02);
            bw(B + 16'h4, 8'h03);
            bw(B + 16'h5, 8'h01);
            per(1'b0, 8'h45, d);
            chk(d, 12);
            chk({31'h0, hirq}, 32'h0);
            per(1'b1, 8'hc5, d);
            chk(d, 6);
            bw(B + 16'h4, 8'h07);
            per(1'b0, 8'hc5, d);
            chk(d, 24);
            $display("mode 0 test done");
        end
    endtask
    task t_mode2;
        begin
            bw(B, 8'h00);
            bw(B + 16'h1, 8'h00);
            bw(B + 16'h4, 8'h01);
            bw(B + 16'h5, 8'h01);
            per(1'b0, 8'he5, d);
            chk(d, 258);
            chk({30'h0, hirq, lirq}, 32'h3);
            $display("mode 2 test done");
        end
    endtask
    task t_mode3;
        begin
            bw(B, 8'h00);
            bw(B + 16'h4, 8'h02);
            bw(B + 16'h5, 8'h00);
            bw(B, 8'hf5);
            pulse(0);
            chk({30'h0, mode}, 32'h3);
            pulse(1);
            rc(B + 16'h2, 8'h02);
            rc(B + 16'h6, 8'h01);
            pulse(2);
            rc(B + 16'h6, 8'h02);
            rc(B + 16'h7, 8'h00);
            chk({30'h0, hirq, lirq}, 32'h0);
            pulse(0);
            @(negedge clk);
            chk({30'h0, hirq, lirq}, 32'h3);
            rc(B + 16'h2, 8'h00);
            $display("mode 3 test done");
        end
    endtask
    task t_mode1;
        begin
            bw(B, 8'h00);
            bw(B + 16'h4, 8'hff);
            bw(B, 8'h50);
            pulse(0);
            pulse(0);
            pulse(1);
            rc(B + 16'h2, 8'h03);
            rc(B + 16'h6, 8'h01);
            bw(B + 16'h2, 8'h55);
            rc(B + 16'h2, 8'h03);
            pulse(2);
            rc(B + 16'h6, 8'h03);
            rc(B + 16'h7, 8'h00);
            $display("mode 1 test done");
        end
    endtask
    task t_hold;
        begin
            bw(B, 8'h00);
            bw(B + 16'h1, 8'h00);
            bw(B + 16'h4, 8'hff);
            bw(B, 8'h40);
            @(posedge clk);
            hold <= 1'b1;
            xfer(1'b0, B + 16'h2, 8'h00, q2);
            repeat (10) @(posedge clk);
            rc(B + 16'h2, q2[7:0]);
            hold <= 1'b0;
            xfer(1'b0, B + 16'h2, 8'h00, q2);
            ce <= 1'b0;
            repeat (20) @(posedge clk);
            ce <= 1'b1;
            rc(B + 16'h2, q2[7:0] + 8'h03);
            bw(B, 8'h00);
            rc(B + 16'h2, 8'h00);
            $display("hold test done");
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Watchdog sized well above the longest expected run.
    initial begin
        #2000000;
        err_total = err_total + 1;
        end_of_test;
    end
    // Main sequence.
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        hold = 1'b0;
        {ea, eb, ec, rd, wr} = 5'h00;
        addr = 18'h0;
        wdata = 32'h0;
        be = 4'h1;
        err_total = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_mode0;
        t_mode2;
        t_mode3;
        t_mode1;
        t_hold;
        end_of_test;
    end
endmodule
